// [logic/mbac_checker.v]
// Mode based access checker for memory and register accesses
//
// The register offsets and register access over APB were decided locally.
`include "mbac_defines.vh"
module mbac_checker (
  input wire pclk, // Clock
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire pready, // APB ready
  output reg [31:0] prdata, // APB read data
  output wire pslverr, // APB error
  input wire mode_set, // Core mode change pulse
  input wire [4:0] mode_new, // Requested one-hot mode
  input wire fw_from_sys, // Firmware entered from system
  input wire cm_start, // Copier start pulse
  input wire cm_done, // Copier finish pulse
  input wire mem_req, // Memory access request
  input wire [1:0] mem_src, // Requester
  input wire [1:0] mem_op, // Read, write, execute
  input wire [3:0] mem_area, // Addressed area
  input wire [15:0] mem_addr, // Virtual address
  input wire exec_in_ee, // Code runs from EEPROM
  output reg mem_ok_ff, // Access granted pulse
  output reg mem_exc_ff, // Access refused pulse
  output reg [15:0] mem_paddr_ff, // Physical address
  input wire sfr_req, // Register access request
  input wire sfr_wr, // Register write
  input wire [2:0] sfr_group, // Register group
  input wire [2:0] sfr_kind, // Special register code
  input wire [3:0] sfr_hw_idx, // Hardware block index
  output reg sfr_ok_ff, // Register granted pulse
  output reg sfr_exc_ff, // Register refused pulse
  output wire [4:0] cpu_mode // Current mode
);

  // Mode states, one-hot
  localparam [4:0] ST_BOOT = `MBAC_M_BOOT;
  localparam [4:0] ST_TEST = `MBAC_M_TEST;
  localparam [4:0] ST_FW = `MBAC_M_FW;
  localparam [4:0] ST_SYS = `MBAC_M_SYS;
  localparam [4:0] ST_USER = `MBAC_M_USER;

  reg [4:0] mode_ff; // Current CPU mode
  reg [4:0] nxt_mode;
  reg [4:0] cm_mode_ff; // Mode latched at copier start
  reg cm_busy_ff; // Copier running
  reg [5:0] ctrl_ff; // Options and firewall bits
  reg [7:0] fwr_lo_ff; // firewall_rights_low
  reg [7:0] fwr_hi_ff; // firewall_rights_high
  reg [7:0] xwb_lo_ff; // exchange_window_base_low
  reg [7:0] xwb_hi_ff; // exchange_window_base_high
  reg [7:0] xws_lo_ff; // exchange_window_size_low
  reg [7:0] xws_hi_ff; // exchange_window_size_high
  reg [15:0] tptr_ff; // Segment table pointer
  reg [5:0] sel_ff; // Selected table entry
  reg [5:0] cur_seg_ff; // Segment of last user fetch
  reg cur_hit_ff; // Last user fetch hit a segment and was granted
  reg [7:0] deny_cnt_ff; // Refused access count

  wire [15:0] fw_rights = {fwr_hi_ff, fwr_lo_ff};
  wire [15:0] xw_base = {xwb_hi_ff, xwb_lo_ff};
  wire [15:0] xw_size = {xws_hi_ff, xws_lo_ff};

  // APB decode; slave answers in the access cycle
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & penable & ~pwrite;
  reg map_hit; // Address decodes to a register
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~map_hit;
  assign cpu_mode = mode_ff;

  // Segment table entries, one per generate slot
  reg [18:0] attr_q [0:`MBAC_SEG_NUM-1]; // rwx plus 16 reg rights
  reg [15:0] first_q [0:`MBAC_SEG_NUM-1];
  reg [15:0] last_q [0:`MBAC_SEG_NUM-1];
  reg [15:0] reloc_q [0:`MBAC_SEG_NUM-1];
  wire [`MBAC_SEG_NUM-1:0] hit_v; // Address falls in entry

  genvar gi;
  generate
    for (gi = 0; gi < `MBAC_SEG_NUM; gi = gi + 1) begin : g_seg
      // Entry storage; attributes reset so every entry is off
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          attr_q[gi] <= 19'h00000;
          first_q[gi] <= 16'h0000;
          last_q[gi] <= 16'h0000;
          reloc_q[gi] <= 16'h0000;
        end else if (apb_wr && sel_ff == gi) begin
          if (paddr == `MBAC_SEG_ATTR)
            attr_q[gi] <= pwdata[18:0];
          if (paddr == `MBAC_SEG_FIRST)
            first_q[gi] <= pwdata[15:0];
          if (paddr == `MBAC_SEG_LAST)
            last_q[gi] <= pwdata[15:0];
          if (paddr == `MBAC_SEG_RELOC)
            reloc_q[gi] <= pwdata[15:0];
        end
      end
      // Entry with no rights never matches
      assign hit_v[gi] = (attr_q[gi][2:0] != 3'h0) &&
        (mem_addr >= first_q[gi]) && (mem_addr <= last_q[gi]);
    end
  endgenerate

  // Lowest matching entry wins; null pointer disables the table
  reg seg_hit;
  reg [5:0] seg_idx;
  integer si;
  always @* begin
    seg_hit = 1'b0;
    seg_idx = 6'h00;
    for (si = `MBAC_SEG_NUM - 1; si >= 0; si = si - 1) begin
      if (hit_v[si]) begin
        seg_hit = 1'b1;
        seg_idx = si[5:0];
      end
    end
    if (tptr_ff == 16'h0000) begin
      seg_hit = 1'b0;
    end
  end

  wire [2:0] seg_rwx = attr_q[seg_idx][2:0];
  wire [15:0] seg_regs = attr_q[cur_seg_ff][18:3];

  // Mode tracking; illegal codes fall back to boot
  always @* begin
    nxt_mode = mode_ff;
    if (mode_set) begin
      case (mode_new)
        ST_BOOT: nxt_mode = ST_BOOT;
        ST_TEST: nxt_mode = ST_TEST;
        ST_FW: nxt_mode = ST_FW;
        ST_SYS: nxt_mode = ST_SYS;
        ST_USER: nxt_mode = ST_USER;
        default: nxt_mode = ST_BOOT;
      endcase
    end
  end

  // Effective mode: copier ignores software mode changes while busy
  wire is_cm = (mem_src == `MBAC_S_CM);
  wire [4:0] eff_mode = (is_cm && cm_busy_ff) ? cm_mode_ff :
    mode_ff;

  // Memory decision
  wire op_r = (mem_op == `MBAC_OP_RD);
  wire op_w = (mem_op == `MBAC_OP_WR);
  wire op_x = (mem_op == `MBAC_OP_EX);
  wire a_rom = (mem_area == `MBAC_A_TEST_ROM) ||
    (mem_area == `MBAC_A_FW_ROM) || (mem_area == `MBAC_A_APP_ROM);
  wire a_ee = (mem_area == `MBAC_A_FW_EE) ||
    (mem_area == `MBAC_A_APP_EE) || (mem_area == `MBAC_A_SEC_ROW);
  wire a_ram = (mem_area == `MBAC_A_FW_RAM) ||
    (mem_area == `MBAC_A_APP_RAM);
  wire a_app_ee = (mem_area == `MBAC_A_APP_EE) ||
    (mem_area == `MBAC_A_SEC_ROW);
  wire in_xw = (mem_area == `MBAC_A_APP_RAM) &&
    (mem_addr >= xw_base) &&
    ({1'b0, mem_addr} < {1'b0, xw_base} + {1'b0, xw_size});
  wire [2:0] op_v = {op_x, op_w, op_r}; // Matches rwx layout
  reg mem_allow; // Combined grant
  reg mem_reloc; // Use segment relocation

  always @* begin
    mem_allow = 1'b0;
    mem_reloc = 1'b0;
    if (mem_src == `MBAC_S_COP) begin
      // Coprocessor owns only its RAM
      mem_allow = (mem_area == `MBAC_A_CO_RAM) & ~op_x;
    end else begin
      case (eff_mode)
        ST_BOOT: begin
          mem_allow = ((mem_area == `MBAC_A_TEST_ROM) & ~op_w) |
            (mem_area == `MBAC_A_FW_EE) |
            ((mem_area == `MBAC_A_FW_RAM) & ~op_x) |
            ((mem_area == `MBAC_A_SEC_ROW) & op_r);
        end
        ST_TEST: begin
          mem_allow = (a_rom & ~op_w) | a_ee | (a_ram & ~op_x);
        end
        ST_FW: begin
          if (mem_area == `MBAC_A_FW_ROM)
            mem_allow = ~op_w;
          else if (mem_area == `MBAC_A_FW_EE)
            mem_allow = ~op_x | ctrl_ff[`MBAC_CTRL_FWEE_X] |
              (op_r & ctrl_ff[`MBAC_CTRL_FWEE_R]);
          else if (a_app_ee)
            // Integrity check of EEPROM writes needs all of it
            mem_allow = ~op_x | (fw_from_sys & ~op_x) |
              ((mem_area == `MBAC_A_SEC_ROW) & op_r);
          else if (mem_area == `MBAC_A_FW_RAM)
            mem_allow = ~op_x;
          else if (in_xw)
            mem_allow = ~op_x;
          else
            mem_allow = 1'b0;
        end
        ST_SYS: begin
          mem_allow = ((mem_area == `MBAC_A_APP_ROM) & ~op_w) |
            a_app_ee | ((mem_area == `MBAC_A_APP_RAM) & ~op_x);
        end
        ST_USER: begin
          mem_reloc = 1'b1;
          if ((mem_area == `MBAC_A_APP_ROM) ||
              (mem_area == `MBAC_A_APP_RAM) || a_app_ee)
            mem_allow = seg_hit && ((seg_rwx & op_v) != 3'h0) &&
              !((mem_area == `MBAC_A_APP_ROM) && op_w) &&
              !((mem_area == `MBAC_A_APP_RAM) && op_x);
        end
        default: mem_allow = 1'b0;
      endcase
    end
    // Configured read blocks override any grant
    if (op_r && a_rom && exec_in_ee && !is_cm &&
        ctrl_ff[`MBAC_CTRL_EE_NO_ROM])
      mem_allow = 1'b0;
    if (op_r && is_cm && a_rom && ctrl_ff[`MBAC_CTRL_CM_NO_ROM])
      mem_allow = 1'b0;
    if (op_r && is_cm && a_ee && ctrl_ff[`MBAC_CTRL_CM_NO_EE])
      mem_allow = 1'b0;
  end

  // Register decision
  wire g_hw = (sfr_group == `MBAC_G_HW);
  wire k_rd = ~sfr_wr;
  reg sfr_allow;

  always @* begin
    sfr_allow = 1'b0;
    case (mode_ff)
      ST_BOOT: sfr_allow = (sfr_group != `MBAC_G_TEST) &&
        (sfr_group != `MBAC_G_SEG_CFG) && (sfr_group != `MBAC_G_CPU_BK);
      ST_TEST: sfr_allow = (sfr_group != `MBAC_G_SEG_CFG) &&
        (sfr_group != `MBAC_G_CPU_BK);
      ST_FW: begin
        if (sfr_group == `MBAC_G_FW_CFG)
          sfr_allow = k_rd;
        else if (sfr_group == `MBAC_G_FW_OS)
          sfr_allow = 1'b1;
        else if (g_hw)
          sfr_allow = fw_rights[sfr_hw_idx] |
            (k_rd && sfr_kind == `MBAC_K_CLKSEL);
        else if (sfr_group == `MBAC_G_CPU_SH)
          sfr_allow = 1'b1;
        else if (sfr_group == `MBAC_G_SYS_MGT)
          sfr_allow = k_rd && sfr_kind == `MBAC_K_CSR;
        else
          sfr_allow = 1'b0;
      end
      ST_SYS: sfr_allow = (sfr_group == `MBAC_G_SEG_CFG) ||
        (sfr_group == `MBAC_G_SYS_MGT) || (sfr_group == `MBAC_G_FW_CFG) ||
        g_hw || (sfr_group == `MBAC_G_CPU_SH) ||
        (sfr_group == `MBAC_G_CPU_BK);
      ST_USER: begin
        if (g_hw)
          sfr_allow = cur_hit_ff & seg_regs[sfr_hw_idx];
        else if (sfr_group == `MBAC_G_SYS_MGT)
          sfr_allow = k_rd && sfr_kind == `MBAC_K_CSR;
        else
          sfr_allow = (sfr_group == `MBAC_G_CPU_SH) ||
            (sfr_group == `MBAC_G_CPU_BK);
      end
      default: sfr_allow = 1'b0;
    endcase
    // Segmentation registers belong to system mode only
    if (sfr_group == `MBAC_G_SEG_CFG && mode_ff != ST_SYS)
      sfr_allow = 1'b0;
    // Never readable registers; random result register never writable
    if (k_rd && (sfr_kind == `MBAC_K_TPTR2 || sfr_kind == `MBAC_K_KEY))
      sfr_allow = 1'b0;
    if (sfr_wr && sfr_kind == `MBAC_K_RNG)
      sfr_allow = 1'b0;
  end

  // APB write side and mode/copier state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= ST_BOOT;
      cm_mode_ff <= ST_BOOT;
      cm_busy_ff <= 1'b0;
      ctrl_ff <= `MBAC_CTRL_RST;
      fwr_lo_ff <= 8'h00;
      fwr_hi_ff <= 8'h00;
      xwb_lo_ff <= 8'h00;
      xwb_hi_ff <= 8'h00;
      xws_lo_ff <= 8'h00;
      xws_hi_ff <= 8'h00;
      tptr_ff <= 16'h0000;
      sel_ff <= 6'h00;
    end else begin
      mode_ff <= nxt_mode;
      // Start wins over done in the same cycle
      if (cm_start) begin
        cm_busy_ff <= 1'b1;
        cm_mode_ff <= mode_ff;
      end else if (cm_done) begin
        cm_busy_ff <= 1'b0;
      end
      if (apb_wr) begin
        case (paddr)
          `MBAC_CTRL: ctrl_ff <= pwdata[5:0];
          `MBAC_FW_RIGHTS_LOW: fwr_lo_ff <= pwdata[7:0];
          `MBAC_FW_RIGHTS_HIGH: fwr_hi_ff <= pwdata[7:0];
          `MBAC_XW_BASE_LOW: xwb_lo_ff <= pwdata[7:0];
          `MBAC_XW_BASE_HIGH: xwb_hi_ff <= pwdata[7:0];
          `MBAC_XW_SIZE_LOW: xws_lo_ff <= pwdata[7:0];
          `MBAC_XW_SIZE_HIGH: xws_hi_ff <= pwdata[7:0];
          `MBAC_TABLE_PTR: tptr_ff <= pwdata[15:0];
          `MBAC_SEG_SEL: sel_ff <= pwdata[5:0];
          default: sel_ff <= sel_ff;
        endcase
      end
    end
  end

  // Decision outputs, one cycle after the request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ok_ff <= 1'b0;
      mem_exc_ff <= 1'b0;
      mem_paddr_ff <= 16'h0000;
      sfr_ok_ff <= 1'b0;
      sfr_exc_ff <= 1'b0;
      cur_seg_ff <= 6'h00;
      cur_hit_ff <= 1'b0;
      deny_cnt_ff <= 8'h00;
    end else begin
      // Refused access never gets a physical address
      mem_ok_ff <= mem_req & mem_allow;
      mem_exc_ff <= mem_req & ~mem_allow;
      if (mem_req && mem_allow)
        mem_paddr_ff <= mem_reloc ? mem_addr + reloc_q[seg_idx] :
          mem_addr;
      sfr_ok_ff <= sfr_req & sfr_allow;
      sfr_exc_ff <= sfr_req & ~sfr_allow;
      // Remember which segment code is fetched from
      if (mem_req && mem_src == `MBAC_S_CPU && op_x &&
          mode_ff == ST_USER) begin
        cur_seg_ff <= seg_idx;
        cur_hit_ff <= seg_hit & mem_allow;
      end
      if (((mem_req & ~mem_allow) | (sfr_req & ~sfr_allow)) &&
          deny_cnt_ff != 8'hFF)
        deny_cnt_ff <= deny_cnt_ff + 8'h01;
    end
  end

  // APB read mux
  always @* begin
    prdata = 32'h00000000;
    map_hit = 1'b1;
    case (paddr)
      `MBAC_CTRL: prdata = {26'h0, ctrl_ff};
      `MBAC_FW_RIGHTS_LOW: prdata = {24'h0, fwr_lo_ff};
      `MBAC_FW_RIGHTS_HIGH: prdata = {24'h0, fwr_hi_ff};
      `MBAC_XW_BASE_LOW: prdata = {24'h0, xwb_lo_ff};
      `MBAC_XW_BASE_HIGH: prdata = {24'h0, xwb_hi_ff};
      `MBAC_XW_SIZE_LOW: prdata = {24'h0, xws_lo_ff};
      `MBAC_XW_SIZE_HIGH: prdata = {24'h0, xws_hi_ff};
      `MBAC_TABLE_PTR: prdata = {16'h0, tptr_ff};
      `MBAC_SEG_SEL: prdata = {26'h0, sel_ff};
      `MBAC_SEG_ATTR: prdata = {13'h0, attr_q[sel_ff]};
      `MBAC_SEG_FIRST: prdata = {16'h0, first_q[sel_ff]};
      `MBAC_SEG_LAST: prdata = {16'h0, last_q[sel_ff]};
      `MBAC_SEG_RELOC: prdata = {16'h0, reloc_q[sel_ff]};
      `MBAC_STATUS: prdata = {10'h0, deny_cnt_ff, cur_hit_ff,
        cur_seg_ff, cm_busy_ff, mode_ff};
      default: map_hit = 1'b0;
    endcase
    if (!apb_rd) begin
      prdata = 32'h00000000;
    end
  end

endmodule

// [logic/mbac_defines.vh]
// Offsets, field codes and reset values for the mode based access checker
`ifndef MBAC_DEFINES_VH
`define MBAC_DEFINES_VH
// APB byte offsets
`define MBAC_CTRL 8'h00
`define MBAC_FW_RIGHTS_LOW 8'h04
`define MBAC_FW_RIGHTS_HIGH 8'h08
`define MBAC_XW_BASE_LOW 8'h0C
`define MBAC_XW_BASE_HIGH 8'h10
`define MBAC_XW_SIZE_LOW 8'h14
`define MBAC_XW_SIZE_HIGH 8'h18
`define MBAC_TABLE_PTR 8'h1C
`define MBAC_SEG_SEL 8'h20
`define MBAC_SEG_ATTR 8'h24
`define MBAC_SEG_FIRST 8'h28
`define MBAC_SEG_LAST 8'h2C
`define MBAC_SEG_RELOC 8'h30
`define MBAC_STATUS 8'h34
// Control register fields
`define MBAC_CTRL_EE_NO_ROM 0
`define MBAC_CTRL_CM_NO_ROM 1
`define MBAC_CTRL_CM_NO_EE 2
`define MBAC_CTRL_FWEE_R 3
`define MBAC_CTRL_FWEE_W 4
`define MBAC_CTRL_FWEE_X 5
`define MBAC_CTRL_RST 6'h00
// Segment table
`define MBAC_SEG_NUM 64
`define MBAC_SEG_IDXW 6
// Mode codes (one-hot): boot, test, firmware, system, user
`define MBAC_M_BOOT 5'h01
`define MBAC_M_TEST 5'h02
`define MBAC_M_FW 5'h04
`define MBAC_M_SYS 5'h08
`define MBAC_M_USER 5'h10
// Memory operations
`define MBAC_OP_RD 2'h0
`define MBAC_OP_WR 2'h1
`define MBAC_OP_EX 2'h2
// Memory areas
`define MBAC_A_TEST_ROM 4'h0
`define MBAC_A_FW_ROM 4'h1
`define MBAC_A_APP_ROM 4'h2
`define MBAC_A_FW_EE 4'h3
`define MBAC_A_APP_EE 4'h4
`define MBAC_A_SEC_ROW 4'h5
`define MBAC_A_FW_RAM 4'h6
`define MBAC_A_APP_RAM 4'h7
`define MBAC_A_CO_RAM 4'h8
// Requesters
`define MBAC_S_CPU 2'h0
`define MBAC_S_CM 2'h1
`define MBAC_S_COP 2'h2
// Register groups
`define MBAC_G_SEG_CFG 3'h0
`define MBAC_G_SYS_MGT 3'h1
`define MBAC_G_FW_CFG 3'h2
`define MBAC_G_FW_OS 3'h3
`define MBAC_G_TEST 3'h4
`define MBAC_G_HW 3'h5
`define MBAC_G_CPU_SH 3'h6
`define MBAC_G_CPU_BK 3'h7
// Special registers
`define MBAC_K_PLAIN 3'h0
`define MBAC_K_CSR 3'h1
`define MBAC_K_CLKSEL 3'h2
`define MBAC_K_TPTR2 3'h3
`define MBAC_K_RNG 3'h4
`define MBAC_K_KEY 3'h5
`endif

// [test/mbac_checker_sva.sv]
// Concurrent checks on the ports of the access checker
`include "mbac_defines.vh"
module mbac_checker_sva (
  input wire pclk, presetn, // Clock, reset
  input wire psel, penable, pwrite, pready, pslverr, // APB control
  input wire [7:0] paddr, // APB address
  input wire [31:0] pwdata, prdata, // APB data
  input wire mode_set, fw_from_sys, cm_start, cm_done, // Mode, copier
  input wire [4:0] mode_new, cpu_mode, // Modes
  input wire mem_req, exec_in_ee, mem_ok_ff, mem_exc_ff, // Memory
  input wire [1:0] mem_src, mem_op, // Requester, operation
  input wire [3:0] mem_area, sfr_hw_idx, // Area, hardware index
  input wire [15:0] mem_addr, mem_paddr_ff, // Addresses
  input wire sfr_req, sfr_wr, sfr_ok_ff, sfr_exc_ff, // Registers
  input wire [2:0] sfr_group, sfr_kind // Group, kind
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Each request gets exactly one answer a cycle later
  mem_answer_a: assert property (mem_req |=> mem_ok_ff != mem_exc_ff)
    else $error("memory request not answered once");
  mem_quiet_a: assert property (!mem_req |=> !mem_ok_ff && !mem_exc_ff)
    else $error("memory answer without request");
  sfr_answer_a: assert property (sfr_req |=> sfr_ok_ff != sfr_exc_ff)
    else $error("register request not answered once");
  // Refusals, grants and invariants that hold whatever the configuration
  seg_deny_a: assert property (sfr_req && sfr_group == `MBAC_G_SEG_CFG &&
    cpu_mode != `MBAC_M_SYS |=> sfr_exc_ff)
    else $error("segmentation register reached outside system");
  bank_deny_a: assert property (sfr_req && sfr_group == `MBAC_G_CPU_BK &&
    (cpu_mode & 5'h07) != 5'h00 |=> sfr_exc_ff)
    else $error("banked register reached in boot, test or firmware");
  shared_ok_a: assert property (sfr_req && sfr_group == `MBAC_G_CPU_SH &&
    sfr_kind == `MBAC_K_PLAIN |=> sfr_ok_ff)
    else $error("shared register refused");
  secret_read_a: assert property (sfr_req && !sfr_wr &&
    (sfr_kind == `MBAC_K_KEY || sfr_kind == `MBAC_K_TPTR2) |=> sfr_exc_ff)
    else $error("secret register readable");
  rng_write_a: assert property (sfr_req && sfr_wr &&
    sfr_kind == `MBAC_K_RNG |=> sfr_exc_ff)
    else $error("random result register writable");
  fw_ram_a: assert property (mem_req && mem_src == `MBAC_S_CPU &&
    cpu_mode == `MBAC_M_FW && mem_area == `MBAC_A_FW_RAM
    |=> mem_exc_ff == ($past(mem_op) == `MBAC_OP_EX))
    else $error("firmware RAM rights wrong");
  sys_ee_a: assert property (mem_req && mem_src == `MBAC_S_CPU &&
    cpu_mode == `MBAC_M_SYS && mem_area == `MBAC_A_APP_EE |=> mem_ok_ff)
    else $error("system EEPROM access refused");
  mode_take_a: assert property (mode_set && $onehot(mode_new)
    |=> cpu_mode == $past(mode_new))
    else $error("mode not taken");
  mode_hot_a: assert property ($onehot(cpu_mode))
    else $error("mode not one-hot");
  deny_hold_a: assert property (mem_exc_ff |-> $stable(mem_paddr_ff))
    else $error("physical address moved on refusal");
endmodule

// [test/mbac_cpu_model.sv]
// Core model issuing memory and register accesses
module mbac_cpu_model (
  input wire pclk, // Clock
  input wire mem_ok_ff, mem_exc_ff, sfr_ok_ff, sfr_exc_ff, // Answers
  output logic mode_set, fw_from_sys, cm_start, cm_done, // Mode, copier
  output logic [4:0] mode_new, // One-hot mode
  output logic mem_req, exec_in_ee, // Memory request
  output logic [1:0] mem_src, mem_op, // Requester, operation
  output logic [3:0] mem_area, // Area
  output logic [15:0] mem_addr, // Virtual address
  output logic sfr_req, sfr_wr, // Register request
  output logic [2:0] sfr_group, sfr_kind, // Group, kind
  output logic [3:0] sfr_hw_idx // Hardware index
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet outputs at time zero
  initial begin
    {mode_set, fw_from_sys, cm_start, cm_done, mode_new} = 9'h000;
    {mem_req, exec_in_ee, mem_src, mem_op, mem_area, mem_addr} = 26'h0;
    {sfr_req, sfr_wr, sfr_group, sfr_kind, sfr_hw_idx} = 12'h000;
  end
  // Mode change pulse, code inverted after
  task automatic set_mode(input logic [4:0] m);
    @(posedge pclk);
    mode_set <= 1'b1;
    mode_new <= m;
    @(posedge pclk);
    mode_set <= 1'b0;
    mode_new <= ~m;
  endtask
  // Copier start or finish pulse
  task automatic copier(input logic start);
    @(posedge pclk);
    cm_start <= start;
    cm_done <= !start;
    @(posedge pclk);
    {cm_start, cm_done} <= 2'b00;
  endtask
  // One memory request; answer read two edges after the request is driven
  task automatic mem(input logic [1:0] s, o, input logic [3:0] a,
    input logic [15:0] ad, input logic ee, output logic [1:0] r);
    @(posedge pclk);
    {mem_req, mem_src, mem_op, mem_area, mem_addr} <= {1'b1, s, o, a, ad};
    exec_in_ee <= ee;
    @(posedge pclk);
    mem_req <= 1'b0;
    mem_addr <= ~ad;
    @(posedge pclk);
    r = {mem_ok_ff, mem_exc_ff};
  endtask
  // One register request
  task automatic sfr(input logic w, input logic [2:0] g, k,
    input logic [3:0] h, output logic [1:0] r);
    @(posedge pclk);
    {sfr_req, sfr_wr, sfr_group, sfr_kind, sfr_hw_idx} <= {1'b1, w, g, k, h};
    @(posedge pclk);
    sfr_req <= 1'b0;
    sfr_hw_idx <= ~h;
    @(posedge pclk);
    r = {sfr_ok_ff, sfr_exc_ff};
  endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench for the access checker
`include "mbac_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [1:0] r;
  logic [4:0] modes [5];
  wire pready, pslverr, mode_set, fw_from_sys, cm_start, cm_done;
  wire mem_req, exec_in_ee, mem_ok_ff, mem_exc_ff;
  wire sfr_req, sfr_wr, sfr_ok_ff, sfr_exc_ff;
  wire [31:0] prdata;
  wire [4:0] mode_new, cpu_mode;
  wire [1:0] mem_src, mem_op;
  wire [3:0] mem_area, sfr_hw_idx;
  wire [15:0] mem_addr, mem_paddr_ff;
  wire [2:0] sfr_group, sfr_kind;
  int fail_count, checks;
  mbac_checker i_dut (.*);
  mbac_cpu_model i_cpu (.*);
  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // APB transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic err);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      fail_count++;
      close_out;
    end
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, rd, e);
    chk(rd, x);
  endtask
  // Access and compare the grant against the expectation
  task automatic mc(input logic [1:0] s, o, input logic [3:0] a,
    input logic [15:0] ad, input logic ee, x);
    i_cpu.mem(s, o, a, ad, ee, r);
    chk({30'h0, r}, {30'h0, x, !x});
  endtask
  task automatic sc(input logic w, input logic [2:0] g, k,
    input logic [3:0] h, input logic x);
    i_cpu.sfr(w, g, k, h, r);
    chk({30'h0, r}, {30'h0, x, !x});
  endtask
  // Register group grant by mode with no firewall or segment rights
  function automatic logic xs(input logic [4:0] m, input logic [2:0] g,
    input logic w);
    logic bt, sy;
    bt = (m == `MBAC_M_BOOT) || (m == `MBAC_M_TEST);
    sy = (m == `MBAC_M_SYS);
    case (g)
      `MBAC_G_SEG_CFG: xs = sy;
      `MBAC_G_SYS_MGT, `MBAC_G_HW: xs = bt || sy;
      `MBAC_G_FW_CFG: xs = bt || sy || (m == `MBAC_M_FW && !w);
      `MBAC_G_FW_OS: xs = bt || m == `MBAC_M_FW;
      `MBAC_G_TEST: xs = (m == `MBAC_M_TEST);
      `MBAC_G_CPU_SH: xs = 1'b1;
      default: xs = sy || m == `MBAC_M_USER;
    endcase
  endfunction
  // Core memory grant in firmware, system and user mode, empty window and table
  function automatic logic xm(input logic [4:0] m, input logic [3:0] a,
    input logic [1:0] o);
    if (m == `MBAC_M_FW)
      xm = (a == `MBAC_A_FW_ROM) ? o != `MBAC_OP_WR :
        (a == `MBAC_A_FW_EE || a == `MBAC_A_APP_EE ||
        a == `MBAC_A_FW_RAM) && o != `MBAC_OP_EX;
    else if (m == `MBAC_M_SYS)
      xm = (a == `MBAC_A_APP_ROM) ? o != `MBAC_OP_WR :
        (a == `MBAC_A_APP_EE) || (a == `MBAC_A_APP_RAM && o != `MBAC_OP_EX);
    else
      xm = 1'b0;
  endfunction
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 43'h0;
    {fail_count, checks} = 0;
    modes = '{`MBAC_M_BOOT, `MBAC_M_TEST, `MBAC_M_FW, `MBAC_M_SYS,
      `MBAC_M_USER};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({27'h0, cpu_mode}, {27'h0, `MBAC_M_BOOT});
    rdc(`MBAC_TABLE_PTR, 32'h0);
    rdc(`MBAC_CTRL, 32'h0);
    apb(1'b0, 8'h3C, 32'h0, rd, e);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      i_cpu.set_mode(modes[i]);
      for (int g = 0; g < 8; g++)
        for (int w = 0; w < 2; w++)
          sc(w[0], g[2:0], `MBAC_K_PLAIN, 4'h0, xs(modes[i], g, w));
      sc(1'b0, `MBAC_G_HW, `MBAC_K_KEY, 4'h0, 1'b0);
      sc(1'b0, `MBAC_G_SYS_MGT, `MBAC_K_TPTR2, 4'h0, 1'b0);
      if (i > 1)
        for (int a = 0; a < 9; a++)
          for (int o = 0; o < 3; o++)
            if (a != `MBAC_A_SEC_ROW)
              mc(`MBAC_S_CPU, o, a, 16'h0, 1'b0, xm(modes[i], a, o));
    end
    $display("test mode tables done");
    i_cpu.set_mode(`MBAC_M_BOOT);
    mc(`MBAC_S_CPU, `MBAC_OP_RD, `MBAC_A_SEC_ROW, 16'h0, 1'b0, 1'b1);
    i_cpu.set_mode(`MBAC_M_FW);
    mc(`MBAC_S_CPU, `MBAC_OP_RD, `MBAC_A_SEC_ROW, 16'h0, 1'b0, 1'b1);
    wr(`MBAC_XW_BASE_HIGH, 32'h01);
    wr(`MBAC_XW_SIZE_LOW, 32'h20);
    mc(`MBAC_S_CPU, `MBAC_OP_RD, `MBAC_A_APP_RAM, 16'h0100, 1'b0, 1'b1);
    mc(`MBAC_S_CPU, `MBAC_OP_WR, `MBAC_A_APP_RAM, 16'h011F, 1'b0, 1'b1);
    mc(`MBAC_S_CPU, `MBAC_OP_RD, `MBAC_A_APP_RAM, 16'h0120, 1'b0, 1'b0);
    mc(`MBAC_S_CPU, `MBAC_OP_RD, `MBAC_A_APP_RAM, 16'h00FF, 1'b0, 1'b0);
    wr(`MBAC_CTRL, 32'h20);
    mc(`MBAC_S_CPU, `MBAC_OP_EX, `MBAC_A_FW_EE, 16'h0, 1'b0, 1'b1);
    wr(`MBAC_FW_RIGHTS_LOW, 32'h08);
    wr(`MBAC_FW_RIGHTS_HIGH, 32'h02);
    sc(1'b0, `MBAC_G_HW, `MBAC_K_PLAIN, 4'h3, 1'b1);
    sc(1'b0, `MBAC_G_HW, `MBAC_K_PLAIN, 4'h2, 1'b0);
    sc(1'b1, `MBAC_G_HW, `MBAC_K_PLAIN, 4'h9, 1'b1);
    sc(1'b0, `MBAC_G_HW, `MBAC_K_CLKSEL, 4'h0, 1'b1);
    sc(1'b0, `MBAC_G_SYS_MGT, `MBAC_K_CSR, 4'h0, 1'b1);
    sc(1'b1, `MBAC_G_SYS_MGT, `MBAC_K_CSR, 4'h0, 1'b0);
    $display("test firmware done");
    i_cpu.set_mode(`MBAC_M_SYS);
    sc(1'b1, `MBAC_G_HW, `MBAC_K_RNG, 4'h0, 1'b0);
    sc(1'b0, `MBAC_G_HW, `MBAC_K_RNG, 4'h0, 1'b1);
    wr(`MBAC_CTRL, 32'h07);
    mc(`MBAC_S_CPU, `MBAC_OP_RD, `MBAC_A_APP_ROM, 16'h0, 1'b1, 1'b0);
    mc(`MBAC_S_CPU, `MBAC_OP_RD, `MBAC_A_APP_ROM, 16'h0, 1'b0, 1'b1);
    i_cpu.copier(1'b1);
    mc(`MBAC_S_CM, `MBAC_OP_RD, `MBAC_A_APP_ROM, 16'h0, 1'b0, 1'b0);
    mc(`MBAC_S_CM, `MBAC_OP_RD, `MBAC_A_APP_EE, 16'h0, 1'b0, 1'b0);
    wr(`MBAC_CTRL, 32'h00);
    i_cpu.set_mode(`MBAC_M_USER);
    mc(`MBAC_S_CM, `MBAC_OP_WR, `MBAC_A_APP_RAM, 16'h0, 1'b0, 1'b1);
    mc(`MBAC_S_CPU, `MBAC_OP_WR, `MBAC_A_APP_RAM, 16'h0, 1'b0, 1'b0);
    i_cpu.copier(1'b0);
    mc(`MBAC_S_CM, `MBAC_OP_WR, `MBAC_A_APP_RAM, 16'h0, 1'b0, 1'b0);
    mc(`MBAC_S_COP, `MBAC_OP_WR, `MBAC_A_CO_RAM, 16'h0, 1'b0, 1'b1);
    mc(`MBAC_S_COP, `MBAC_OP_RD, `MBAC_A_APP_RAM, 16'h0, 1'b0, 1'b0);
    $display("test options and copier done");
    // Disabled entry 0 overlaps entry 2 and must not win
    wr(`MBAC_TABLE_PTR, 32'h01);
    for (int s = 0; s < 3; s += 2) begin
      wr(`MBAC_SEG_SEL, s);
      wr(`MBAC_SEG_ATTR, s ? 32'h85 : 32'h0);
      wr(`MBAC_SEG_FIRST, 32'h1000);
      wr(`MBAC_SEG_LAST, 32'h1FFF);
      wr(`MBAC_SEG_RELOC, 32'h0200);
    end
    mc(`MBAC_S_CPU, `MBAC_OP_EX, `MBAC_A_APP_ROM, 16'h1000, 1'b0, 1'b1);
    chk({16'h0, mem_paddr_ff}, 32'h1200);
    mc(`MBAC_S_CPU, `MBAC_OP_WR, `MBAC_A_APP_EE, 16'h1004, 1'b0, 1'b0);
    chk({16'h0, mem_paddr_ff}, 32'h1200);
    mc(`MBAC_S_CPU, `MBAC_OP_RD, `MBAC_A_APP_RAM, 16'h1FFF, 1'b0, 1'b1);
    mc(`MBAC_S_CPU, `MBAC_OP_RD, `MBAC_A_APP_RAM, 16'h2000, 1'b0, 1'b0);
    sc(1'b1, `MBAC_G_HW, `MBAC_K_PLAIN, 4'h4, 1'b1);
    sc(1'b1, `MBAC_G_HW, `MBAC_K_PLAIN, 4'h5, 1'b0);
    sc(1'b0, `MBAC_G_SYS_MGT, `MBAC_K_CSR, 4'h0, 1'b1);
    $display("test user segments done");
    close_out;
  end
endmodule
bind mbac_checker mbac_checker_sva i_sva (.*);
